//--- rsmseq_cfg_if.sv
// Monitor configuration bundle between the top and the keeper
`timescale 1ns/10ps
interface rsmseq_cfg_if;
  logic wr_en; // Software writes enable
  logic wr_sel; // Software writes select
  logic wr_en_val; // Written enable value
  logic wr_sel_val; // Written select value
  logic force_on; // POR or power-fail restores defaults
  logic sleep; // Device asleep
  logic en_eff; // Effective enable
  logic sel_eff; // Effective select
  logic en_user; // Last value software set
  logic sel_user; // Last value software set
  modport top (output wr_en, wr_sel, wr_en_val, wr_sel_val, force_on,
    sleep, input en_eff, sel_eff, en_user, sel_user);
  modport keep (input wr_en, wr_sel, wr_en_val, wr_sel_val, force_on,
    sleep, output en_eff, sel_eff, en_user, sel_user);
endinterface : rsmseq_cfg_if

//--- rsmseq_cfg_keep.sv
// Monitor enable and select, surviving ordinary resets
`timescale 1ns/10ps
module rsmseq_cfg_keep (
  input wire logic CLK, // System clock
  input wire logic RST, // Power-on reset
  rsmseq_cfg_if.keep cfg // Configuration bundle
);
  logic en_q; // Stored enable
  logic sel_q; // Stored select
  // Only POR, power-fail and software writes touch these
  always_ff @(posedge CLK) begin
    if (RST || cfg.force_on) begin
      en_q <= 1'b1;
      sel_q <= 1'b1;
    end else begin
      if (cfg.wr_en) begin
        en_q <= cfg.wr_en_val;
      end
      if (cfg.wr_sel) begin
        sel_q <= cfg.wr_sel_val;
      end
    end
  end
  // Sleep masks the monitor; wake restores stored values
  assign cfg.en_eff = en_q && !cfg.sleep;
  assign cfg.sel_eff = sel_q && !cfg.sleep;
  assign cfg.en_user = en_q;
  assign cfg.sel_user = sel_q;
  property p_sleep_off;
    @(posedge CLK) disable iff (RST) cfg.sleep |-> !cfg.sel_eff;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("monitor live in sleep");
endmodule : rsmseq_cfg_keep

//--- rsmseq_params.svh
// Offsets, field positions, reset values and timing counts
`ifndef RSMSEQ_PARAMS_SVH
`define RSMSEQ_PARAMS_SVH
`define RSMSEQ_CLK_MHZ 100
`define RSMSEQ_OFF_MONCTL 8'h00
`define RSMSEQ_OFF_RESET_SOURCE_REG 8'h04
`define RSMSEQ_OFF_CTRL 8'h08
`define RSMSEQ_OFF_STAT 8'h0C
`define RSMSEQ_BIT_MON_EN 7
`define RSMSEQ_BIT_ABOVE 6
`define RSMSEQ_BIT_WARN_OK 5
`define RSMSEQ_BIT_POR_FLAG 1
`define RSMSEQ_BIT_SWRST 4
`define RSMSEQ_BIT_FLERR 6
`define RSMSEQ_PORT_RESET 8'hFF
`define RSMSEQ_PC_RESET 16'h0000
`define RSMSEQ_WDT_DIV 12
`define RSMSEQ_POR_DELAY_MS 15
`define RSMSEQ_POR_DELAY_CYC (`RSMSEQ_POR_DELAY_MS * 1000 * `RSMSEQ_CLK_MHZ)
`endif

//--- rsmseq_pkg.sv
// Types shared by the reset sequencer files
package rsmseq_pkg;
  typedef enum logic [3:0] {
    RSMSEQ_POR  = 4'b0001,
    RSMSEQ_WAIT = 4'b0010,
    RSMSEQ_RUN  = 4'b0100,
    RSMSEQ_HOLD = 4'b1000
  } rsmseq_state_type;
endpackage : rsmseq_pkg

//--- rsmseq_supply_model.sv
// Supply comparators and external reset circuit on the far side
`timescale 1ns/10ps
module rsmseq_supply_model (
  input wire logic vbat_up, // Battery above power-on level
  input wire logic vdd_up, // Core supply above reset level
  input wire logic warn_up, // Core supply above warn level
  input wire logic ext_low, // External circuit pulls pin low
  input wire logic pin_out, // Device drive value
  input wire logic pin_oe, // Device drive enable
  output logic vbat_above_por, // Battery comparator output
  output logic vdd_above_rst, // Reset comparator output
  output logic vdd_above_warn, // Warn comparator output
  output logic pin_level // Resolved reset pin level
);
  // Comparators follow the supplies directly
  assign vbat_above_por = vbat_up;
  assign vdd_above_rst = vdd_up;
  assign vdd_above_warn = warn_up;
  // External pull-up wins only when nobody drives the pin
  assign pin_level = ext_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
endmodule : rsmseq_supply_model

//--- rsmseq_top.sv
// Reset sequencer with supply monitor and AXI4-Lite registers
`timescale 1ns/10ps
`include "rsmseq_params.svh"
// How it works
// - Reset halts core, resets registers, pins, timers
// - RAM is never cleared by reset
// - Port latches load all ones, pull-ups on
// - POR leaves reset pin undriven, pull-up off
// - Monitor reset drives reset pin low
// - Exit clears PC, selects internal oscillator
// - Watchdog enabled, clocked system clock over twelve
// - Hold reset until battery above threshold, delay
// - Release delay chosen by battery voltage
// - POR and power-fail set power flag; others clear it
// - POR and power-fail enable and select monitor
// - Low core supply holds reset until recovered
// - After power-fail power flag reads one
// - Other resets keep monitor settings
// - Sleep disables monitor; wake restores settings
// - Warning bit follows warn comparator, may interrupt
// - Flash write without monitor causes reset
// - Monitor reset skips the release delay
// - Control register bits seven, six, five
module rsmseq_top import rsmseq_pkg::*; #(
  parameter int POR_DELAY_CYC = `RSMSEQ_POR_DELAY_CYC
) (
  input wire logic CLK, // System clock
  input wire logic RST, // Sync reset, active high
  input wire logic VBAT_ABOVE_POR, // Battery above power-on level
  input wire logic VDD_ABOVE_RST, // Core supply above reset level
  input wire logic VDD_ABOVE_WARN, // Core supply above warn level
  input wire logic [1:0] VBAT_RANGE, // 0:0.9V 1:1.8V 2,3:3.6V
  input wire logic SLEEP, // Device in sleep
  input wire logic FLASH_WR_REQ, // Flash erase or write attempt
  input wire logic RST_PIN_IN, // Level on external reset pin
  output logic RST_PIN_OUT, // Reset pin drive value
  output logic RST_PIN_OE, // Reset pin drive enable
  output logic RST_PIN_PULLUP, // Reset pin weak pull-up
  output logic CORE_RESET, // Holds core and registers
  output logic [15:0] PC_LOAD, // Program counter on release
  output logic OSC_INTERNAL, // Internal oscillator selected
  output logic [7:0] PORT_LATCH, // Port latch reset value
  output logic PORT_OPEN_DRAIN, // Ports open-drain
  output logic PORT_PULLUP, // Weak pull-ups on ports
  output logic WDT_ENABLE, // Watchdog enabled
  output logic WDT_TICK, // Watchdog clock tick
  output logic WARN_IRQ, // Early warning interrupt
  input wire logic [7:0] S_AXI_AWADDR, // Write address
  input wire logic S_AXI_AWVALID, // Write address valid
  output logic S_AXI_AWREADY, // Write address ready
  input wire logic [31:0] S_AXI_WDATA, // Write data
  input wire logic [3:0] S_AXI_WSTRB, // Write strobes
  input wire logic S_AXI_WVALID, // Write data valid
  output logic S_AXI_WREADY, // Write data ready
  output logic [1:0] S_AXI_BRESP, // Write response
  output logic S_AXI_BVALID, // Write response valid
  input wire logic S_AXI_BREADY, // Write response ready
  input wire logic [7:0] S_AXI_ARADDR, // Read address
  input wire logic S_AXI_ARVALID, // Read address valid
  output logic S_AXI_ARREADY, // Read address ready
  output logic [31:0] S_AXI_RDATA, // Read data
  output logic [1:0] S_AXI_RRESP, // Read response
  output logic S_AXI_RVALID, // Read valid
  input wire logic S_AXI_RREADY // Read ready
);
  localparam logic [1:0] OKAY = 2'b00; // AXI OKAY
  localparam logic [1:0] SLVERR = 2'b10; // AXI SLVERR
  rsmseq_state_type st_q, st_d; // Sequencer state
  logic [31:0] dly_q; // Release delay counter
  logic [31:0] dly_lim; // Delay for present battery range
  logic mon_cause_q; // Last reset from supply monitor
  logic por_flag_q; // Power-on flag
  logic flerr_q; // Flash error flag
  logic swrst_q; // Software reset flag
  logic warn_irq_en_q; // Warning interrupt mask
  logic warn_seen_q; // Sticky warning event
  logic soft_req; // Software or flash reset request
  logic mon_trip; // Monitor demands reset
  logic aw_q, w_q; // Write address/data held
  logic [7:0] awaddr_q; // Held write address
  logic [31:0] wdata_q; // Held write data
  logic [3:0] wstrb_q; // Held strobes
  logic bvalid_q; // Write response pending
  logic [1:0] bresp_q; // Write response code
  logic rvalid_q; // Read data pending
  logic [31:0] rdata_q; // Read data
  logic [1:0] rresp_q; // Read response code
  logic wr_fire; // Write executes this cycle
  logic wr_b0; // Low byte written
  logic wr_monctl, wr_reset_source_reg, wr_ctrl, wr_stat; // Write decode
  logic wr_hit; // Write to mapped register
  logic [31:0] rd_mux; // Read data select
  logic rd_hit; // Read of mapped register
  logic [7:0] monctl_rd; // Control register image
  logic [7:0] reset_source_reg_rd; // Reset source image
  rsmseq_cfg_if cfg (); // Monitor configuration bundle
  default clocking dcb @(posedge CLK); endclocking // Assertion clock
  default disable iff (RST); // Assertions idle in reset

  rsmseq_cfg_keep u_keep (
    .CLK(CLK),
    .RST(RST),
    .cfg(cfg)
  );

  rsmseq_wdt_div #(.DIV(`RSMSEQ_WDT_DIV)) u_wdt (
    .CLK(CLK),
    .RST(CORE_RESET),
    .tick(WDT_TICK)
  );

  // Delay limit from battery level, counted in clocks
  assign dly_lim = (VBAT_RANGE == 2'd0) ? 32'(POR_DELAY_CYC / 5) :
                   (VBAT_RANGE == 2'd1) ? 32'((POR_DELAY_CYC * 7) / 15) :
                   32'(POR_DELAY_CYC);
  // Monitor trips only when live, selected and supply low
  assign mon_trip = cfg.en_eff && cfg.sel_eff && !VDD_ABOVE_RST;
  // Flash write with monitor disabled is an error
  assign soft_req = swrst_q || (FLASH_WR_REQ && !cfg.en_user);

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      RSMSEQ_POR: begin
        if (VBAT_ABOVE_POR) begin
          st_d = RSMSEQ_WAIT;
        end
      end
      RSMSEQ_WAIT: begin
        if (!VBAT_ABOVE_POR) begin
          st_d = RSMSEQ_POR;
        end else if (dly_q >= dly_lim - 32'd1) begin
          st_d = RSMSEQ_RUN;
        end
      end
      RSMSEQ_RUN: begin
        if (mon_trip || soft_req || !RST_PIN_IN) begin
          st_d = RSMSEQ_HOLD;
        end
      end
      RSMSEQ_HOLD: begin
        // No power-on delay on this path
        if (!mon_trip && (RST_PIN_IN || mon_cause_q)) begin // Own pin drive
          st_d = RSMSEQ_RUN;
        end
      end
      default: st_d = RSMSEQ_POR;
    endcase
    if (!VBAT_ABOVE_POR) begin
      st_d = RSMSEQ_POR;
    end
  end

  // State and delay counter
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q <= RSMSEQ_POR;
      dly_q <= 32'd0;
    end else begin
      st_q <= st_d;
      dly_q <= (st_q == RSMSEQ_WAIT) ? dly_q + 32'd1 : 32'd0;
    end
  end

  // Cause of the present hold
  always_ff @(posedge CLK) begin
    if (RST) begin
      mon_cause_q <= 1'b0;
    end else if (st_q == RSMSEQ_RUN && st_d == RSMSEQ_HOLD) begin
      mon_cause_q <= mon_trip;
    end
  end

  // Power-on flag: POR/power-fail set, others clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      por_flag_q <= 1'b1;
    end else if (st_q == RSMSEQ_HOLD && st_d == RSMSEQ_RUN) begin
      por_flag_q <= mon_cause_q;
    end else if (st_q == RSMSEQ_WAIT) begin
      por_flag_q <= 1'b1;
    end
  end

  // Flash error and software reset flags
  always_ff @(posedge CLK) begin
    if (RST || st_q == RSMSEQ_POR) begin
      flerr_q <= 1'b0;
      swrst_q <= 1'b0;
    end else if (st_q == RSMSEQ_RUN && st_d == RSMSEQ_HOLD) begin
      flerr_q <= FLASH_WR_REQ && !cfg.en_user;
      swrst_q <= 1'b0;
    end else if (wr_reset_source_reg && wr_b0) begin
      swrst_q <= wdata_q[`RSMSEQ_BIT_SWRST];
    end
  end

  // Monitor bundle drive: defaults on POR and power-fail
  assign cfg.force_on = (st_q == RSMSEQ_POR) ||
                        (st_q == RSMSEQ_HOLD && mon_cause_q);
  assign cfg.sleep = SLEEP;
  assign cfg.wr_en = wr_monctl && wr_b0;
  assign cfg.wr_en_val = wdata_q[`RSMSEQ_BIT_MON_EN];
  // Selection rides on the power flag bit
  assign cfg.wr_sel = wr_reset_source_reg && wr_b0;
  assign cfg.wr_sel_val = wdata_q[`RSMSEQ_BIT_POR_FLAG];

  // Early warning sticky and mask; set beats clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      warn_seen_q <= 1'b0;
      warn_irq_en_q <= 1'b0;
    end else begin
      if (!VDD_ABOVE_WARN) begin
        warn_seen_q <= 1'b1;
      end else if (wr_stat && wr_b0 && wdata_q[0]) begin
        warn_seen_q <= 1'b0;
      end
      if (CORE_RESET || (wr_ctrl && wr_b0)) begin
        warn_irq_en_q <= wdata_q[0] && !CORE_RESET;
      end
    end
  end
  assign WARN_IRQ = warn_seen_q && warn_irq_en_q;

  // Core-side outputs while and after reset
  assign CORE_RESET = (st_q != RSMSEQ_RUN);
  assign PORT_LATCH = `RSMSEQ_PORT_RESET;
  assign PORT_OPEN_DRAIN = CORE_RESET;
  assign PORT_PULLUP = 1'b1;
  assign PC_LOAD = `RSMSEQ_PC_RESET;
  assign OSC_INTERNAL = 1'b1;
  assign WDT_ENABLE = 1'b1;
  // Reset pin: float on POR, driven low on monitor hold
  assign RST_PIN_OUT = 1'b0;
  assign RST_PIN_OE = (st_q == RSMSEQ_HOLD && mon_cause_q);
  assign RST_PIN_PULLUP = (st_q != RSMSEQ_POR && st_q != RSMSEQ_WAIT);

  // Register images
  assign monctl_rd = {cfg.en_user, VDD_ABOVE_RST, VDD_ABOVE_WARN, 5'b0_0000};
  assign reset_source_reg_rd = {1'b0, flerr_q, 1'b0, swrst_q, 2'b00, por_flag_q, 1'b0};

  // AXI write channel capture
  assign S_AXI_AWREADY = !aw_q && !bvalid_q;
  assign S_AXI_WREADY = !w_q && !bvalid_q;
  assign wr_fire = aw_q && w_q && !bvalid_q;
  assign wr_b0 = wstrb_q[0];
  assign wr_monctl = wr_fire && awaddr_q == `RSMSEQ_OFF_MONCTL;
  assign wr_reset_source_reg = wr_fire && awaddr_q == `RSMSEQ_OFF_RESET_SOURCE_REG;
  assign wr_ctrl = wr_fire && awaddr_q == `RSMSEQ_OFF_CTRL;
  assign wr_stat = wr_fire && awaddr_q == `RSMSEQ_OFF_STAT;
  assign wr_hit = wr_monctl || wr_reset_source_reg || wr_ctrl || wr_stat;

  // Write address and data holding
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_q <= 1'b1;
        awaddr_q <= {S_AXI_AWADDR[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CLK) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q <= OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? OKAY : SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  // Read decode
  assign S_AXI_ARREADY = !rvalid_q;
  assign rd_hit = S_AXI_ARADDR[7:4] == 4'h0;
  assign rd_mux =
    (S_AXI_ARADDR[3:2] == 2'd0) ? {24'h00_0000, monctl_rd} :
    (S_AXI_ARADDR[3:2] == 2'd1) ? {24'h00_0000, reset_source_reg_rd} :
    (S_AXI_ARADDR[3:2] == 2'd2) ? {31'h0000_0000, warn_irq_en_q} :
    {31'h0000_0000, warn_seen_q};

  // Read response
  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_hit ? rd_mux : 32'h0000_0000;
      rresp_q <= rd_hit ? OKAY : SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  property p_por_pin;
    st_q == RSMSEQ_POR |-> !RST_PIN_OE && !RST_PIN_PULLUP;
  endproperty
  a_por_pin: assert property (p_por_pin) else $error("pin in POR");
  property p_mon_pin;
    mon_trip && !CORE_RESET && VBAT_ABOVE_POR |=> RST_PIN_OE && CORE_RESET;
  endproperty
  a_mon_pin: assert property (p_mon_pin) else $error("trip missed");
  property p_no_delay;
    RST_PIN_OE && !mon_trip && VBAT_ABOVE_POR |=> !CORE_RESET;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("late exit");
  property p_flag_mon;
    st_q == RSMSEQ_HOLD && mon_cause_q && st_d == RSMSEQ_RUN |=> por_flag_q;
  endproperty
  a_flag_mon: assert property (p_flag_mon) else $error("flag lost");
  property p_flag_clr;
    st_q == RSMSEQ_HOLD && !mon_cause_q && st_d == RSMSEQ_RUN |=> !por_flag_q;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag kept");
  property p_wait_min;
    $rose(st_q == RSMSEQ_WAIT) |-> CORE_RESET[*2];
  endproperty
  a_wait_min: assert property (p_wait_min) else $error("early exit");
  property p_flerr;
    !CORE_RESET && FLASH_WR_REQ && !cfg.en_user |=> CORE_RESET;
  endproperty
  a_flerr: assert property (p_flerr) else $error("no flash reset");
  property p_defaults;
    st_q == RSMSEQ_POR |=> cfg.en_user && cfg.sel_user;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults");
  property p_irq_off;
    CORE_RESET |=> !WARN_IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq live");
endmodule : rsmseq_top

//--- rsmseq_wdt_div.sv
// Watchdog clock prescaler, divide by a fixed count
`timescale 1ns/10ps
`include "rsmseq_params.svh"
module rsmseq_wdt_div #(
  parameter int DIV = `RSMSEQ_WDT_DIV
) (
  input wire logic CLK, // System clock
  input wire logic RST, // Any reset
  output logic tick // One pulse per DIV clocks
);
  logic [3:0] cnt_q; // Divider count
  // Counts DIV cycles then pulses
  always_ff @(posedge CLK) begin
    if (RST || cnt_q == 4'(DIV - 1)) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign tick = !RST && cnt_q == 4'(DIV - 1);
endmodule : rsmseq_wdt_div

//--- tb_top.sv
// Register-level testbench for the reset sequencer
`timescale 1ns/10ps
module tb_top;
  localparam int DLY = 30; // Shortened release delay
  logic CLK = 1'b0; // System clock
  logic RST = 1'b1; // Power-on reset
  logic vbat_up = 1'b0, vdd_up = 1'b1, warn_up = 1'b1, ext_low = 1'b0;
  logic [1:0] VBAT_RANGE = 2'd2; // Battery range
  logic SLEEP = 1'b0, FLASH_WR_REQ = 1'b0;
  logic VBAT_ABOVE_POR, VDD_ABOVE_RST, VDD_ABOVE_WARN, RST_PIN_IN;
  logic RST_PIN_OUT, RST_PIN_OE, RST_PIN_PULLUP, CORE_RESET, OSC_INTERNAL;
  logic PORT_OPEN_DRAIN, PORT_PULLUP, WDT_ENABLE, WDT_TICK, WARN_IRQ;
  logic [15:0] PC_LOAD; // Program counter load value
  logic [7:0] PORT_LATCH; // Port latch value
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'h0; // Write strobes
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0;
  logic S_AXI_BREADY = 1'b1, S_AXI_RREADY = 1'b1; // Always accepting
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int miscompares = 0; // Mismatch count
  int checks_done = 0; // Comparison count
  // Clock at 100 MHz
  always #5 CLK = ~CLK;
  rsmseq_supply_model sup_u (.vbat_up(vbat_up), .vdd_up(vdd_up),
    .warn_up(warn_up), .ext_low(ext_low), .pin_out(RST_PIN_OUT),
    .pin_oe(RST_PIN_OE), .vbat_above_por(VBAT_ABOVE_POR),
    .vdd_above_rst(VDD_ABOVE_RST), .vdd_above_warn(VDD_ABOVE_WARN),
    .pin_level(RST_PIN_IN));
  rsmseq_top #(.POR_DELAY_CYC(DLY)) dut_u (.CLK(CLK), .RST(RST),
    .VBAT_ABOVE_POR(VBAT_ABOVE_POR), .VDD_ABOVE_RST(VDD_ABOVE_RST),
    .VDD_ABOVE_WARN(VDD_ABOVE_WARN), .VBAT_RANGE(VBAT_RANGE),
    .SLEEP(SLEEP), .FLASH_WR_REQ(FLASH_WR_REQ), .RST_PIN_IN(RST_PIN_IN),
    .RST_PIN_OUT(RST_PIN_OUT), .RST_PIN_OE(RST_PIN_OE),
    .RST_PIN_PULLUP(RST_PIN_PULLUP), .CORE_RESET(CORE_RESET),
    .PC_LOAD(PC_LOAD), .OSC_INTERNAL(OSC_INTERNAL),
    .PORT_LATCH(PORT_LATCH), .PORT_OPEN_DRAIN(PORT_OPEN_DRAIN),
    .PORT_PULLUP(PORT_PULLUP), .WDT_ENABLE(WDT_ENABLE),
    .WDT_TICK(WDT_TICK), .WARN_IRQ(WARN_IRQ),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY));
  // Verdict and end of run
  task automatic test_done;
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // Word compare, reports at once
  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Single bit compare
  task automatic chkb(input string what, input logic e, input logic g);
    chk(what, {31'b0, e}, {31'b0, g});
  endtask : chkb
  // AXI4-Lite write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] resp);
    logic aw_done, w_done;
    int n;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_WSTRB <= 4'h1;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    while (!(aw_done && w_done) && n < 50) begin
      @(posedge CLK);
      n++;
      if (!aw_done && S_AXI_AWREADY === 1'b1) begin
        aw_done = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (!w_done && S_AXI_WREADY === 1'b1) begin
        w_done = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    while (S_AXI_BVALID !== 1'b1 && n < 50) begin
      @(posedge CLK);
      n++;
    end
    resp = S_AXI_BRESP;
    chkb("write answered", 1'b1, n < 50);
  endtask : axi_wr
  // AXI4-Lite read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] resp);
    int n;
    n = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (S_AXI_ARREADY !== 1'b1 && n < 50);
    S_AXI_ARVALID <= 1'b0;
    while (S_AXI_RVALID !== 1'b1 && n < 50) begin
      @(posedge CLK);
      n++;
    end
    d = S_AXI_RDATA;
    resp = S_AXI_RRESP;
    chkb("read answered", 1'b1, n < 50);
  endtask : axi_rd
  // Write ignoring the response
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] r;
    axi_wr(a, v, r);
  endtask : wr
  // Read and compare masked bits
  task automatic rdc(input string what, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(what, e, d & m);
  endtask : rdc
  // Bounded wait for the core reset level
  task automatic wait_core(input logic lvl, input int lim, output int n);
    n = 0;
    while (CORE_RESET !== lvl && n < lim) begin
      @(posedge CLK);
      n++;
    end
  endtask : wait_core
  // Full power-on: hold, then battery rises, then timed release
  task automatic power_on(input logic [1:0] rng, input int e);
    int n;
    RST <= 1'b1;
    vbat_up <= 1'b0;
    VBAT_RANGE <= rng;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    repeat (3) @(posedge CLK);
    chkb("core held", 1'b1, CORE_RESET);
    chkb("pin oe por", 1'b0, RST_PIN_OE);
    chkb("pin pullup por", 1'b0, RST_PIN_PULLUP);
    chk("latch in reset", 32'h0000_00FF, {24'b0, PORT_LATCH});
    chkb("open drain", 1'b1, PORT_OPEN_DRAIN);
    vbat_up <= 1'b1;
    wait_core(1'b0, e + 20, n);
    chkb("release delay", 1'b1, n >= e && n <= e + 4);
  endtask : power_on
  // Hang guard
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
  // Main sequence
  initial begin
    int n;
    logic [31:0] d;
    logic [1:0] r;
    power_on(2'd0, DLY / 5);
    power_on(2'd1, DLY * 7 / 15);
    power_on(2'd2, DLY);
    chk("pc", 32'h0000_0000, {16'b0, PC_LOAD});
    chkb("osc", 1'b1, OSC_INTERNAL);
    chk("latch", 32'h0000_00FF, {24'b0, PORT_LATCH});
    chkb("pullup", 1'b1, PORT_PULLUP);
    chkb("open drain run", 1'b0, PORT_OPEN_DRAIN);
    chkb("wdt en", 1'b1, WDT_ENABLE);
    chkb("pin pullup run", 1'b1, RST_PIN_PULLUP);
    for (n = 0; n < 30 && WDT_TICK !== 1'b1; n++) @(posedge CLK);
    @(posedge CLK);
    for (n = 1; n < 30 && WDT_TICK !== 1'b1; n++) @(posedge CLK);
    chk("wdt period", 32'd12, n);
    rdc("monctl", 8'h00, 32'h0000_00E0, 32'h0000_00E0);
    rdc("por flag", 8'h04, 32'h0000_0002, 32'h0000_0002);
    wr(8'h00, 32'h0000_0080);
    rdc("monctl ro", 8'h00, 32'h0000_00E0, 32'h0000_00E0);
    axi_rd(8'h10, d, r);
    chk("unmapped rd", 32'h0000_0002, {30'b0, r});
    chk("unmapped data", 32'h0000_0000, d);
    axi_wr(8'h20, 32'h0000_00FF, r);
    chk("unmapped wr", 32'h0000_0002, {30'b0, r});
    // Early warning, masked then unmasked, then cleared
    warn_up <= 1'b0;
    repeat (3) @(posedge CLK);
    rdc("warn low", 8'h00, 32'h0000_0020, 32'h0000_0000);
    chkb("irq masked", 1'b0, WARN_IRQ);
    wr(8'h08, 32'h0000_0001);
    repeat (2) @(posedge CLK);
    chkb("irq on", 1'b1, WARN_IRQ);
    warn_up <= 1'b1;
    wr(8'h0C, 32'h0000_0001);
    repeat (2) @(posedge CLK);
    chkb("irq clear", 1'b0, WARN_IRQ);
    // Core supply dip: pin low, hold, quick release
    vdd_up <= 1'b0;
    wait_core(1'b1, 10, n);
    chkb("mon reset", 1'b1, n < 10);
    repeat (DLY + 10) @(posedge CLK);
    chkb("still held", 1'b1, CORE_RESET);
    chkb("pin oe", 1'b1, RST_PIN_OE);
    chkb("pin low", 1'b0, RST_PIN_IN);
    vdd_up <= 1'b1;
    wait_core(1'b0, DLY, n);
    chkb("no delay", 1'b1, n < DLY);
    chkb("pin free", 1'b0, RST_PIN_OE);
    rdc("flag after fail", 8'h04, 32'h0000_0002, 32'h0000_0002);
    // Software disables, deselects, then soft reset keeps that
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0010);
    wait_core(1'b1, 20, n);
    chkb("soft reset", 1'b1, n < 20);
    wait_core(1'b0, 60, n);
    chkb("soft reset done", 1'b1, n < 60);
    rdc("flag soft", 8'h04, 32'h0000_0002, 32'h0000_0000);
    rdc("kept off", 8'h00, 32'h0000_0080, 32'h0000_0000);
    vdd_up <= 1'b0;
    repeat (10) @(posedge CLK);
    chkb("off no reset", 1'b0, CORE_RESET);
    vdd_up <= 1'b1;
    // Flash attempt with monitor off
    FLASH_WR_REQ <= 1'b1;
    @(posedge CLK);
    FLASH_WR_REQ <= 1'b0;
    wait_core(1'b1, 10, n);
    chkb("flash reset", 1'b1, n < 10);
    wait_core(1'b0, 60, n);
    rdc("flash flag", 8'h04, 32'h0000_0040, 32'h0000_0040);
    // Enable first, then select with the flag bit set
    wr(8'h00, 32'h0000_0080);
    wr(8'h04, 32'h0000_0002);
    SLEEP <= 1'b1;
    vdd_up <= 1'b0;
    repeat (10) @(posedge CLK);
    chkb("sleep no reset", 1'b0, CORE_RESET);
    vdd_up <= 1'b1;
    repeat (2) @(posedge CLK);
    SLEEP <= 1'b0;
    rdc("wake enable", 8'h00, 32'h0000_0080, 32'h0000_0080);
    vdd_up <= 1'b0;
    wait_core(1'b1, 10, n);
    chkb("wake select", 1'b1, n < 10);
    vdd_up <= 1'b1;
    wait_core(1'b0, DLY, n);
    // External pin reset clears the power flag
    ext_low <= 1'b1;
    wait_core(1'b1, 10, n);
    ext_low <= 1'b0;
    wait_core(1'b0, 60, n);
    rdc("flag pin", 8'h04, 32'h0000_0002, 32'h0000_0000);
    // Power-on restores enable after software cleared it
    wr(8'h00, 32'h0000_0000);
    power_on(2'd3, DLY);
    rdc("por enable", 8'h00, 32'h0000_0080, 32'h0000_0080);
    test_done();
  end
endmodule : tb_top
